// ==== hw/ilsync_consts.vh ====
// Purpose: shared constants for the line-sync execution unit
// Assumes: 32-bit addresses, 100 MHz core clock
// Notes:   exception codes are the unit's own encoding
`ifndef ILSYNC_CONSTS_VH
`define ILSYNC_CONSTS_VH
`define ILS_XC_NONE      4'h0
`define ILS_XC_TLB_REFL  4'h1
`define ILS_XC_TLB_INVL  4'h2
`define ILS_XC_ADDR_LD   4'h3
`define ILS_XC_CACHE_ERR 4'h4
`define ILS_XC_BUS_ERR   4'h5
`define ILS_XC_RSVD_INS  4'h6
`define ILS_XC_WATCH     4'h7
`define ILS_CAUSE_LOAD   1'b0
`define ILS_CAUSE_STORE  1'b1
`define ILS_ST_IDLE      3'h0
`define ILS_ST_XLATE     3'h1
`define ILS_ST_LOCAL     3'h2
`define ILS_ST_GLOBAL    3'h3
`define ILS_ST_DONE      3'h4
`define ILS_OFFS_BITS    16
`define ILS_RESP_TO_NS   1000
`define ILS_RESP_TO_CYC  ((`ILS_RESP_TO_NS + 9) / 10)
`define ILS_KSEG_TOP     32'h80000000
`endif

// ==== hw/ils_addr_gen.v ====
// Purpose: effective address from base register and 16-bit offset
// Assumes: inputs from the same clock domain
// Notes:   result is registered
module ils_addr_gen
(
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire        load_in,
    input  wire [31:0] base_in,
    input  wire [15:0] offset_in,
    output wire [31:0] eaddr_out
);
    reg [31:0] eaddr_r;
    wire [31:0] sext_w;

    // sign extension keeps negative offsets reaching lower lines
    assign sext_w = {{16{offset_in[15]}}, offset_in};
    assign eaddr_out = eaddr_r;

    // latch on issue so base may change after
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            eaddr_r <= 32'h00000000;
        else if (load_in)
            eaddr_r <= base_in + sext_w;
    end
endmodule

// ==== hw/ils_line_mask.v ====
// Purpose: line-align the effective address to one cache line
// Assumes: line size a power of two
// Notes:   pure combinational decode
module ils_line_mask
#(
    parameter LINE_BITS = 5
)
(
    input  wire [31:0] eaddr_in,
    output wire [31:0] line_addr_out
);
    // only the single containing line is named
    assign line_addr_out = {eaddr_in[31:LINE_BITS],
                            {LINE_BITS{1'b0}}};
endmodule

// ==== hw/ils_unit.v ====
// Purpose: execute the instruction-cache line synchronize operation
// Assumes: pipeline issues one op at a time; translation returns in order
// Notes:   exception outputs are registered; handshakes are combinational;
//          the response budget restarts for the broadcast phase;
//          a locked line finishes clean with no cache request
`include "ilsync_consts.vh"

// Operation
// - effective address is base plus sign-extended 16-bit offset.
// - act only on the one line holding the effective address.
// - tlb refill and invalid faults reported with load cause.
// - never tlb modified, never store-cause refill.
// - never execute-inhibit or read-inhibit faults.
// - writeback cache error reported as cache error.
// - errored bus transaction raises bus error exception.
// - optional load address error for faulting kernel regions.
// - data watch triggering fixed by a parameter.
// - locked lines are left untouched.
// - accepted in every privilege mode.
// - local caches always, shared outer caches where needed.
// - with hardware-coherent icaches the op is a no-operation.
// - broadcast only when the attribute is coherent.
// - all affected cache levels handled alike, global or local.
// - latest release always globalizes coherent addresses.
// - first-release device treats opcode as reserved instruction.
module ils_unit
#(
    parameter LINE_BITS      = 5,
    parameter ARCH_REL       = 6,
    parameter HW_ICOHERENT   = 0,
    parameter KSEG_ADDR_ERR  = 1,
    parameter WATCH_TRIGGERS = 0,
    parameter RESP_TO_CYC    = `ILS_RESP_TO_CYC
)
(
    input  wire        clk_in,
    input  wire        arst_n_in,
    // issue from the pipeline
    input  wire        issue_valid_in,
    output wire        issue_ready_out,
    input  wire [31:0] base_in,
    input  wire [15:0] offset_in,
    input  wire        user_mode_in,
    // translation lookup
    output wire        xlate_req_out,
    output wire [31:0] xlate_vaddr_out,
    output wire        xlate_cause_out,
    input  wire        xlate_done_in,
    input  wire        xlate_miss_in,
    input  wire        xlate_invalid_in,
    input  wire        xlate_coherent_in,
    input  wire        watch_match_in,
    // local caches and shared outer levels
    output wire        local_req_out,
    output wire        outer_req_out,
    output wire [31:0] line_addr_out,
    input  wire        line_locked_in,
    input  wire        local_done_in,
    input  wire        outer_done_in,
    input  wire        wb_err_in,
    input  wire        bus_err_in,
    // broadcast to other coherent icaches
    output wire        bcast_req_out,
    input  wire        bcast_done_in,
    // completion to pipeline
    output reg         done_out,
    output reg         exc_out,
    output reg  [3:0]  exc_code_out,
    output reg         exc_cause_out,
    output reg  [31:0] bad_vaddr_out,
    output reg         watch_out
);
    // sequencing state
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         global_r;
    reg         locked_r;
    reg         local_ok_r;
    reg         outer_ok_r;
    reg  [15:0] tmo_r;
    reg         err_r;
    reg  [3:0]  err_code_r;
    reg         user_r;

    // combinational decode of the current step
    reg         pend_exc;
    reg  [3:0]  pend_code;
    reg         finish;

    // derived strobes
    wire [31:0] eaddr_w;
    wire [31:0] line_w;
    wire        accept_w;
    wire        rsvd_w;
    wire        kseg_w;
    wire        tmo_hit_w;
    wire        enter_glob_w;
    wire        user_mode_in_r_w;

    // kernel region test, used only by the translate check;
    // unsigned compare: the upper half of the space is kernel only
    function is_kernel;
        input [31:0] a;
        begin
            is_kernel = (a >= `ILS_KSEG_TOP);
        end
    endfunction

    // acceptance ignores privilege mode: no coprocessor check on this op;
    // one op at a time, so ready stands only while idle
    assign issue_ready_out = (state_r == `ILS_ST_IDLE);
    assign accept_w = issue_valid_in && issue_ready_out;
    assign rsvd_w = (ARCH_REL < 2);
    assign tmo_hit_w = (tmo_r == 16'h0000);

    // the broadcast gets a fresh response budget of its own, so a slow
    // local answer cannot eat into the time the other icaches need
    assign enter_glob_w = (state_r == `ILS_ST_LOCAL) &&
                          (state_nxt == `ILS_ST_GLOBAL);

    // address sum registered at acceptance, stable for the whole op
    ils_addr_gen u_addr
    (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .load_in   (accept_w),
        .base_in   (base_in),
        .offset_in (offset_in),
        .eaddr_out (eaddr_w)
    );

    // line alignment of the registered address
    ils_line_mask #(.LINE_BITS(LINE_BITS)) u_mask
    (
        .eaddr_in      (eaddr_w),
        .line_addr_out (line_w)
    );

    // user mode captured at issue, used for the kernel region fault;
    // a kernel caller reaches the upper region without any fault
    assign user_mode_in_r_w = user_r && is_kernel(eaddr_w);
    assign kseg_w = (KSEG_ADDR_ERR != 0) && user_mode_in_r_w;

    // privilege level of the op in flight
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            user_r <= 1'b0;
        else if (accept_w)
            user_r <= user_mode_in;
    end

    // translation always asks with load cause, never store
    assign xlate_req_out   = (state_r == `ILS_ST_XLATE) && !kseg_w;
    assign xlate_vaddr_out = eaddr_w;
    assign xlate_cause_out = `ILS_CAUSE_LOAD;
    assign line_addr_out   = line_w;

    // locked lines and errors suppress any cache action
    assign local_req_out = (state_r == `ILS_ST_LOCAL) && !local_ok_r &&
                           !line_locked_in && !err_r;
    assign outer_req_out = (state_r == `ILS_ST_LOCAL) && !outer_ok_r &&
                           !line_locked_in && !err_r;
    assign bcast_req_out = (state_r == `ILS_ST_GLOBAL) && !err_r;

    // next state and exception selection
    always @*
    begin
        state_nxt = state_r;
        pend_exc  = 1'b0;
        pend_code = `ILS_XC_NONE;
        finish    = 1'b0;
        case (state_r)
            `ILS_ST_IDLE:
            begin
                // reserved opcode and the coherent no-op finish at once
                if (accept_w)
                begin
                    if (rsvd_w)
                    begin
                        pend_exc  = 1'b1;
                        pend_code = `ILS_XC_RSVD_INS;
                        finish    = 1'b1;
                    end
                    else if (HW_ICOHERENT != 0)
                        finish = 1'b1;
                    else
                        state_nxt = `ILS_ST_XLATE;
                end
            end
            `ILS_ST_XLATE:
            begin
                // no protection inhibit faults are ever raised here
                // address error is decided before any lookup goes out
                if (kseg_w)
                begin
                    pend_exc  = 1'b1;
                    pend_code = `ILS_XC_ADDR_LD;
                    finish    = 1'b1;
                end
                else if (xlate_done_in)
                begin
                    if (xlate_miss_in)
                    begin
                        pend_exc  = 1'b1;
                        pend_code = `ILS_XC_TLB_REFL;
                        finish    = 1'b1;
                    end
                    else if (xlate_invalid_in)
                    begin
                        pend_exc  = 1'b1;
                        pend_code = `ILS_XC_TLB_INVL;
                        finish    = 1'b1;
                    end
                    else
                        state_nxt = `ILS_ST_LOCAL;
                end
            end
            `ILS_ST_LOCAL:
            begin
                // an error outranks a lock; a lock alone ends clean
                if (err_r || locked_r)
                begin
                    pend_exc  = err_r;
                    pend_code = err_code_r;
                    finish    = 1'b1;
                end
                else if (local_ok_r && outer_ok_r)
                begin
                    if (global_r)
                        state_nxt = `ILS_ST_GLOBAL;
                    else
                        finish = 1'b1;
                end
            end
            `ILS_ST_GLOBAL:
            begin
                // the op ends once the icaches answer, or at once on an error or timeout
                if (err_r)
                begin
                    pend_exc  = 1'b1;
                    pend_code = err_code_r;
                    finish    = 1'b1;
                end
                else if (bcast_done_in)
                    finish = 1'b1;
            end
            default:
                state_nxt = `ILS_ST_IDLE;
        endcase
        // every finish returns to idle: ready rises with done
        if (finish)
            state_nxt = `ILS_ST_IDLE;
    end

    // state, progress flags and error capture
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r    <= `ILS_ST_IDLE;
            global_r   <= 1'b0;
            locked_r   <= 1'b0;
            local_ok_r <= 1'b0;
            outer_ok_r <= 1'b0;
            err_r      <= 1'b0;
            err_code_r <= `ILS_XC_NONE;
            tmo_r      <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            // progress flags restart while the translation is pending
            if (state_r == `ILS_ST_XLATE)
            begin
                // coherent attribute and release 2 or later decide globalize
                global_r   <= xlate_coherent_in &&
                              (ARCH_REL >= 6 || ARCH_REL >= 2);
                locked_r   <= 1'b0;
                local_ok_r <= 1'b0;
                outer_ok_r <= 1'b0;
                err_r      <= 1'b0;
                // no code of an earlier fault may ride on a clean finish
                err_code_r <= `ILS_XC_NONE;
                tmo_r      <= RESP_TO_CYC[15:0];
            end
            else if (state_r == `ILS_ST_LOCAL ||
                     state_r == `ILS_ST_GLOBAL)
            begin
                // the lock is sampled only while the line phase runs
                if (state_r == `ILS_ST_LOCAL && line_locked_in)
                    locked_r <= 1'b1;
                // each level answers once; its request drops on that answer
                if (local_done_in)
                    local_ok_r <= 1'b1;
                if (outer_done_in)
                    outer_ok_r <= 1'b1;
                // reload on the way into the broadcast, else count down
                if (enter_glob_w)
                    tmo_r <= RESP_TO_CYC[15:0];
                else if (!tmo_hit_w)
                    tmo_r <= tmo_r - 16'h0001;
                // a silent responder ends as a bus error
                // writeback errors outrank plain bus errors
                if (wb_err_in && !err_r)
                begin
                    err_r      <= 1'b1;
                    err_code_r <= `ILS_XC_CACHE_ERR;
                end
                else if ((bus_err_in || tmo_hit_w) && !err_r)
                begin
                    err_r      <= 1'b1;
                    err_code_r <= `ILS_XC_BUS_ERR;
                end
            end
        end
    end

    // completion report, faulting address kept on exception
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            done_out      <= 1'b0;
            exc_out       <= 1'b0;
            exc_code_out  <= `ILS_XC_NONE;
            exc_cause_out <= `ILS_CAUSE_LOAD;
            bad_vaddr_out <= 32'h00000000;
            watch_out     <= 1'b0;
        end
        else
        begin
            done_out      <= finish;
            exc_out       <= finish && pend_exc;
            exc_code_out  <= finish ? pend_code : `ILS_XC_NONE;
            // cause stays load type: no store-cause fault leaves this unit
            exc_cause_out <= `ILS_CAUSE_LOAD;
            watch_out     <= (WATCH_TRIGGERS != 0) && xlate_done_in &&
                             (state_r == `ILS_ST_XLATE) &&
                             watch_match_in;
            if (finish && pend_exc)
                bad_vaddr_out <= eaddr_w;
        end
    end
endmodule

// ==== verif/icache_sva.sv ====
// Purpose: port-level checker for the line-sync unit
// Assumes: one clock, async active-low reset, LINE_BITS of 5
// Notes:   bound to every ils_unit instance
module icache_sva
(
    input logic        clk_in,
    input logic        arst_n_in,
    input logic        issue_valid_in,
    input logic        issue_ready_out,
    input logic [31:0] base_in,
    input logic [15:0] offset_in,
    input logic        xlate_req_out,
    input logic [31:0] xlate_vaddr_out,
    input logic        xlate_cause_out,
    input logic        xlate_done_in,
    input logic        xlate_coherent_in,
    input logic        local_req_out,
    input logic        outer_req_out,
    input logic [31:0] line_addr_out,
    input logic        line_locked_in,
    input logic        bcast_req_out,
    input logic        done_out,
    input logic        exc_out,
    input logic [3:0]  exc_code_out,
    input logic        exc_cause_out,
    input logic        watch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    logic [31:0] ea_r;
    logic        coh_r;
    // own copy of the address sum, taken when the op is accepted
    always_ff @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in)
        begin
            ea_r  <= 32'h0;
            coh_r <= 1'b0;
        end
        else
        begin
            if (issue_valid_in && issue_ready_out)
                ea_r <= base_in + {{16{offset_in[15]}}, offset_in};
            if (xlate_done_in)
                coh_r <= xlate_coherent_in;
        end
    a_load_cause: assert property (
        !xlate_cause_out && !exc_cause_out)
        else $error("store cause seen");
    a_exc_done: assert property (exc_out |-> done_out)
        else $error("exception without done");
    a_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    a_take_busy: assert property (
        issue_valid_in && issue_ready_out |=> !issue_ready_out)
        else $error("ready while busy");
    a_ea_form: assert property (
        xlate_req_out |-> xlate_vaddr_out == ea_r)
        else $error("effective address wrong");
    a_line_one: assert property (
        (local_req_out || outer_req_out) |->
        line_addr_out == {ea_r[31:5], 5'h00})
        else $error("line address wrong");
    a_lock_skip: assert property (
        (local_req_out || outer_req_out) |-> !line_locked_in)
        else $error("locked line touched");
    a_bcast_coh: assert property (bcast_req_out |-> coh_r)
        else $error("broadcast without coherent attribute");
    a_no_watch: assert property (!watch_out)
        else $error("watch raised while disabled");
    a_code_range: assert property (
        exc_out |-> exc_code_out inside {[4'h1:4'h5]})
        else $error("exception code out of set");
    a_code_idle: assert property (
        !exc_out |-> exc_code_out == 4'h0)
        else $error("code shown without exception");
endmodule
bind ils_unit icache_sva i_sva (.clk_in, .arst_n_in, .issue_valid_in,
    .issue_ready_out, .base_in, .offset_in, .xlate_req_out, .xlate_vaddr_out,
    .xlate_cause_out, .xlate_done_in, .xlate_coherent_in, .local_req_out,
    .outer_req_out, .line_addr_out, .line_locked_in, .bcast_req_out,
    .done_out, .exc_out, .exc_code_out, .exc_cause_out, .watch_out);

// ==== verif/icache_mem_model.sv ====
// Purpose: translation, cache and broadcast responders
// Assumes: request bits {bcast, outer, local, xlate}
// Notes:   mode 1 writeback error, 2 bus error, 3 outer never answers
module icache_mem_model
(
    input  logic       clk_in,
    input  logic [3:0] req_in,
    input  logic [1:0] err_mode_in,
    input  logic [1:0] dly_in,
    output logic [3:0] done_out,
    output logic       wb_err_out,
    output logic       bus_err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [4] = '{0, 0, 0, 0};
    initial done_out = 4'h0;
    // answer each level after dly_in cycles, one-cycle done pulse
    always @(negedge clk_in)
        for (int i = 0; i < 4; i++)
        begin
            cnt[i] = (req_in[i] && !done_out[i]) ? cnt[i] + 1 : 0;
            done_out[i] <= req_in[i] && !done_out[i] && cnt[i] > dly_in
                && !(i == 2 && err_mode_in == 2'd3);
        end
    // errors ride on the done of the level that failed
    assign wb_err_out  = done_out[1] && err_mode_in == 2'd1;
    assign bus_err_out = done_out[2] && err_mode_in == 2'd2;
endmodule

// ==== verif/icache_line_sync_op_tb_top.sv ====
// Purpose: self-checking bench for the line-sync unit
// Assumes: RESP_TO_CYC cut to 8 so the timeout case stays short
// Notes:   inputs change on the falling edge only
module icache_line_sync_op_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, arst_n_in = 1'b0, issue_valid_in = 1'b0;
    logic [31:0] base_in = 32'h0, line_addr_out, xlate_vaddr_out;
    logic [31:0] bad_vaddr_out;
    logic [15:0] offset_in = 16'h0;
    logic user_mode_in = 1'b0, xlate_miss_in = 1'b0, xlate_invalid_in = 1'b0;
    logic xlate_coherent_in = 1'b0, line_locked_in = 1'b0;
    logic watch_match_in = 1'b0; // raised in one case; watch option is off
    logic xlate_done_in, local_done_in, outer_done_in, bcast_done_in;
    logic wb_err_in, bus_err_in, issue_ready_out, xlate_req_out;
    logic xlate_cause_out, local_req_out, outer_req_out, bcast_req_out;
    logic done_out, exc_out, exc_cause_out, watch_out, got_exc, wseen;
    logic [3:0] exc_code_out, got_code, seen, dn, rq;
    logic [1:0] err_mode = 2'd0, dly = 2'd0;
    int num_errors = 0, check_count = 0;
    initial forever #5 clk_in = ~clk_in;
    assign rq = {bcast_req_out, outer_req_out, local_req_out, xlate_req_out};
    assign {bcast_done_in, outer_done_in, local_done_in, xlate_done_in} = dn;
    ils_unit #(.RESP_TO_CYC(8)) i_dut (.clk_in, .arst_n_in, .issue_valid_in,
        .issue_ready_out, .base_in, .offset_in, .user_mode_in, .xlate_req_out,
        .xlate_vaddr_out, .xlate_cause_out, .xlate_done_in, .xlate_miss_in,
        .xlate_invalid_in, .xlate_coherent_in, .watch_match_in, .local_req_out,
        .outer_req_out, .line_addr_out, .line_locked_in, .local_done_in,
        .outer_done_in, .wb_err_in, .bus_err_in, .bcast_req_out, .bcast_done_in,
        .done_out, .exc_out, .exc_code_out, .exc_cause_out, .bad_vaddr_out,
        .watch_out);
    icache_mem_model i_far (.clk_in, .req_in(rq), .err_mode_in(err_mode),
        .dly_in(dly), .done_out(dn), .wb_err_out(wb_err_in),
        .bus_err_out(bus_err_in));
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one op: hold valid across the accepting edge, wait for done
    task automatic run_op(input logic [31:0] b, input logic [15:0] o,
        input logic u, input logic [1:0] em, input logic [3:0] fl);
        int n;
        @(negedge clk_in); // next op only after the last done
        base_in = b;
        offset_in = o;
        user_mode_in = u;
        err_mode = em;
        {line_locked_in, xlate_coherent_in} = fl[3:2];
        {xlate_invalid_in, xlate_miss_in} = fl[1:0];
        issue_valid_in = 1'b1;
        @(negedge clk_in);
        issue_valid_in = 1'b0;
        seen = 4'h0;
        wseen = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 300)
        begin
            seen = seen | rq;
            wseen = wseen | watch_out;
            @(negedge clk_in);
            n++;
        end
        got_exc = exc_out;
        got_code = exc_code_out;
        chk("done", 1, n < 300);
    endtask
    // two lines stepped by the line size, negative offset, slow and prompt
    // targets are data lines, never the lines this code runs
    task automatic t_plain();
        for (int i = 0; i < 2; i++)
        begin
            dly = i * 3;
            run_op(32'h00001000 + i * 32, 16'hFFF0, 1'b0, 2'd0, 4'h0);
            chk("plain exc", 0, got_exc);
            chk("plain reqs", 4'h7, seen);
            chk("plain vaddr", 32'h00000FF0 + i * 32, xlate_vaddr_out);
            chk("plain line", 32'h00000FE0 + i * 32, line_addr_out);
        end
        $display("t_plain done");
    endtask
    task automatic t_coh();
        watch_match_in = 1'b1;
        run_op(32'h00003000, 16'h0044, 1'b0, 2'd0, 4'h4);
        watch_match_in = 1'b0;
        chk("coh watch", 0, wseen);
        chk("coh exc", 0, got_exc);
        chk("coh reqs", 4'hF, seen);
        $display("t_coh done");
    endtask
    // faults: miss, invalid, writeback, bus, timeout, user in kernel space
    task automatic t_fault();
        logic [3:0] fl [6] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
        logic [1:0] em [6] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd3, 2'd0};
        logic [3:0] cd [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h5, 4'h3};
        logic [31:0] b;
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 5) ? 32'h80000000 : 32'h00002000;
            run_op(b, 16'h0010, i == 5, em[i], fl[i]);
            chk("fault exc", 1, got_exc);
            chk("fault code", cd[i], got_code);
            if (i < 2)
                chk("fault no cache", 0, seen[3:1]);
            @(negedge clk_in);
            chk("fault vaddr", b + 32'h10, bad_vaddr_out);
        end
        $display("t_fault done");
    endtask
    task automatic t_mode_lock();
        run_op(32'h80000000, 16'h0010, 1'b0, 2'd0, 4'h0);
        chk("kernel exc", 0, got_exc);
        run_op(32'h00004000, 16'h0020, 1'b1, 2'd0, 4'h0);
        chk("user exc", 0, got_exc);
        run_op(32'h00005000, 16'h0000, 1'b0, 2'd0, 4'h8);
        chk("lock exc", 0, got_exc);
        chk("lock code", 0, got_code);
        chk("lock reqs", 0, seen[2:1]);
        $display("t_mode_lock done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk_in);
        arst_n_in = 1'b1;
        @(negedge clk_in);
        chk("ready after reset", 1, issue_ready_out);
        chk("done after reset", 0, done_out);
        t_plain();
        t_coh();
        t_fault();
        t_mode_lock();
        conclude();
    end
    // watchdog well beyond the 130 or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        conclude();
    end
endmodule
